// [rcf_pkg.sv]
// Constants for the remapping capability fields block: register offsets,
// field positions, reported capability values and check encodings.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package rcf_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ADR_CAP_LO   = 8'h00;
    localparam logic [7:0] ADR_CAP_HI   = 8'h04;
    localparam logic [7:0] ADR_CHK_ALO  = 8'h08;
    localparam logic [7:0] ADR_CHK_AHI  = 8'h0C;
    localparam logic [7:0] ADR_CHK_CTRL = 8'h10;
    localparam logic [7:0] ADR_CHK_STAT = 8'h14;

    // ****************************************************************
    // Capability field positions (64-bit word)
    // ****************************************************************
    localparam int FOFS_LSB  = 24;
    localparam int FOFS_MSB  = 33;
    localparam int OLD_BIT   = 23;
    localparam int ZLEN_BIT  = 22;
    localparam int MAXW_LSB  = 16;
    localparam int MAXW_MSB  = 21;
    localparam int AWMSK_LSB = 8;
    localparam int AWMSK_MSB = 12;

    // ****************************************************************
    // Reported values of this implementation
    // ****************************************************************
    localparam logic [9:0] FOFS_VAL     = 10'h020;
    localparam logic       ZLEN_VAL     = 1'b1;
    localparam logic [5:0] MAXW_CFG     = 6'h2F;
    localparam logic [5:0] HAW_M1       = 6'h2D;
    localparam logic       SLX_VAL      = 1'b1;
    localparam logic [4:0] AWMSK_CFG    = 5'h04;
    localparam logic [5:0] MAXW_VAL     =
        (MAXW_CFG >= HAW_M1) ? MAXW_CFG : HAW_M1;
    localparam logic [4:0] AWMSK_VAL    = SLX_VAL ? AWMSK_CFG : 5'h00;

    // ****************************************************************
    // Adjusted guest widths per mask bit
    // ****************************************************************
    localparam logic [6:0] AW_3LVL = 7'h27;
    localparam logic [6:0] AW_4LVL = 7'h30;
    localparam logic [6:0] AW_5LVL = 7'h39;

    // ****************************************************************
    // Check control and status fields
    // ****************************************************************
    localparam logic [1:0] KIND_DMA   = 2'h0;
    localparam logic [1:0] KIND_XLATE = 2'h1;
    localparam logic [1:0] KIND_ZLEN  = 2'h2;
    localparam int CTL_KIND_LSB = 0;
    localparam int CTL_SEL_LSB  = 2;
    localparam int CTL_WO_BIT   = 5;
    localparam int ST_DONE      = 0;
    localparam int ST_BLOCK     = 1;
    localparam int ST_FAULT     = 2;
    localparam int ST_NULL      = 3;
    localparam int ST_BADW      = 4;
    localparam int ST_CNT_LSB   = 8;
    localparam logic [7:0] CNT_MAX = 8'hFF;

endpackage : rcf_pkg

// [rcf_chk_if.sv]
// Carrier between the top and the address checker: one request,
// one registered verdict.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface rcf_chk_if;
    // Request
    logic        start;
    logic [63:0] addr;
    logic [1:0]  kind;
    logic [2:0]  sel;
    logic        wr_only;
    // Verdict
    logic        done;
    logic        blocked;
    logic        fault;
    logic        null_cpl;
    logic        bad_width;

    modport top (output start, addr, kind, sel, wr_only,
                 input  done, blocked, fault, null_cpl, bad_width);
    modport chk (input  start, addr, kind, sel, wr_only,
                 output done, blocked, fault, null_cpl, bad_width);
endinterface : rcf_chk_if
`default_nettype wire

// [rcf_cap_build.sv]
// Builds the capability word and holds it constant from reset onward.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rcf_cap_build
    import rcf_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        ce,
    // Capability word
    output logic [63:0]      cap
);
    typedef struct packed {
        logic [63:0] cap;
    } rcf_cb_t;

    rcf_cb_t st_r;
    rcf_cb_t st_nxt;

    // Word loaded in every reset cycle; no path lets anything else alter it
    always_comb begin
        st_nxt = st_r;
        if (reset) begin
            st_nxt.cap = 64'h0;
            st_nxt.cap[FOFS_MSB:FOFS_LSB]   = FOFS_VAL;
            st_nxt.cap[OLD_BIT]             = 1'b0;
            st_nxt.cap[ZLEN_BIT]            = ZLEN_VAL;
            st_nxt.cap[MAXW_MSB:MAXW_LSB]   = MAXW_VAL;
            st_nxt.cap[AWMSK_MSB:AWMSK_LSB] = AWMSK_VAL;
        end
    end

    // State register, frozen when ce is low except for reset
    always_ff @(posedge clock) begin
        if (ce || reset) begin
            st_r <= st_nxt;
        end
    end

    assign cap = st_r.cap;
endmodule : rcf_cap_build
`default_nettype wire

// [rcf_addr_check.sv]
// Judges one request against the guest address limits of the unit.
// Assumes the capability word is stable and start is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module rcf_addr_check
    import rcf_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        ce,
    // Capability word
    input  wire logic [63:0] cap,
    // Request and verdict
    rcf_chk_if.chk           chk
);
    typedef struct packed {
        logic done;
        logic blocked;
        logic fault;
        logic null_cpl;
        logic bad_width;
    } rcf_ck_t;

    rcf_ck_t    st_r;
    rcf_ck_t    st_nxt;
    logic [6:0] maxw_w;
    logic [6:0] tbl_w;
    logic [6:0] lim_w;
    logic [4:0] mask;
    logic       bad_w;
    logic       over;
    logic       zl_block;

    // Width limits of the request
    always_comb begin
        mask   = cap[AWMSK_MSB:AWMSK_LSB];
        maxw_w = {1'b0, cap[MAXW_MSB:MAXW_LSB]} + 7'h01;
        case (chk.sel)
            3'h1:    tbl_w = AW_3LVL;
            3'h2:    tbl_w = AW_4LVL;
            3'h3:    tbl_w = AW_5LVL;
            default: tbl_w = 7'h00;
        endcase
        // Reserved mask bits and unreported widths are both refused;
        // only selects 1..3 reach the mask, so two index bits suffice
        bad_w    = (tbl_w == 7'h00) || !mask[chk.sel[1:0]];
        lim_w    = (tbl_w < maxw_w) ? tbl_w : maxw_w;
        over     = (chk.addr >> lim_w) != 64'h0;
        zl_block = (chk.kind == KIND_ZLEN) && chk.wr_only
                   && !cap[ZLEN_BIT];
    end

    // Verdict flags, held until the next request; done pulses for one cycle
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (reset) begin
            st_nxt = '0;
        end else if (chk.start) begin
            st_nxt.done      = 1'b1;
            st_nxt.bad_width = bad_w;
            st_nxt.null_cpl  = 1'b0;
            st_nxt.blocked   = 1'b0;
            st_nxt.fault     = 1'b0;
            if (chk.kind == KIND_XLATE) begin
                st_nxt.null_cpl = over || bad_w;
            end else begin
                st_nxt.blocked = over || bad_w || zl_block;
                st_nxt.fault   = over || bad_w || zl_block;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (ce || reset) begin
            st_r <= st_nxt;
        end
    end

    assign chk.done      = st_r.done;
    assign chk.blocked   = st_r.blocked;
    assign chk.fault     = st_r.fault;
    assign chk.null_cpl  = st_r.null_cpl;
    assign chk.bad_width = st_r.bad_width;
endmodule : rcf_addr_check
`default_nettype wire

// [rcf_top.sv]
// Capability register bits 33:8 of an I/O address remapping unit with a
// request checker that applies the reported limits, behind Wishbone.
// Assumes a classic single-cycle Wishbone master and one clock domain.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bits 33:24 give the first fault register at base plus 16 times it.
// - Bit 23 always reads zero.
// - With bit 22 clear, zero-length reads to write-only pages fault.
// - With bit 22 set, such reads pass; this unit reports it set.
// - Bits 21:16 report the largest guest address width minus one.
// - Untranslated DMA above the reported width is blocked.
// - Device-TLB requests above the width get a null R=W=0 answer.
// - Each request is limited to the smaller of that width and its table.
// - The reported width is never below the host address width.
// - Bits 12:8 flag 39, 48 and 57-bit table widths; bits 0, 4 reserved.
// - Without second-level translation the width mask reads zero.
module rcf_top
    import rcf_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        ce,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [31:0] alo;
        logic [31:0] ahi;
        logic [1:0]  kind;
        logic [2:0]  sel;
        logic        wr_only;
        logic        start;
        logic        pend;
        logic [4:0]  flags;
        logic [7:0]  cnt;
    } rcf_top_t;

    rcf_top_t    st_r;
    rcf_top_t    st_nxt;
    logic [63:0] cap;
    logic [31:0] ctrl_rd;
    logic [31:0] stat_rd;
    logic [31:0] ctrl_wr;
    logic        req;

    rcf_chk_if chk ();

    // ****************************************************************
    // Submodules
    // ****************************************************************
    rcf_cap_build u_cap (
        .clock (clock),
        .reset (reset),
        .ce    (ce),
        .cap   (cap)
    );

    rcf_addr_check u_chk (
        .clock (clock),
        .reset (reset),
        .ce    (ce),
        .cap   (cap),
        .chk   (chk)
    );

    // Request to the checker
    assign chk.start   = st_r.start;
    assign chk.addr    = {st_r.ahi, st_r.alo};
    assign chk.kind    = st_r.kind;
    assign chk.sel     = st_r.sel;
    assign chk.wr_only = st_r.wr_only;

    // ****************************************************************
    // Register views
    // ****************************************************************
    always_comb begin
        ctrl_rd = 32'h0;
        ctrl_rd[CTL_KIND_LSB +: 2] = st_r.kind;
        ctrl_rd[CTL_SEL_LSB +: 3]  = st_r.sel;
        ctrl_rd[CTL_WO_BIT]        = st_r.wr_only;
        stat_rd = 32'h0;
        stat_rd[ST_DONE]           = st_r.flags[ST_DONE] && !st_r.pend;
        stat_rd[ST_BLOCK]          = st_r.flags[ST_BLOCK];
        stat_rd[ST_FAULT]          = st_r.flags[ST_FAULT];
        stat_rd[ST_NULL]           = st_r.flags[ST_NULL];
        stat_rd[ST_BADW]           = st_r.flags[ST_BADW];
        stat_rd[ST_CNT_LSB +: 8]   = st_r.cnt;
        // Byte lanes merged into the control word
        for (int b = 0; b < 4; b++) begin
            ctrl_wr[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8]
                                            : ctrl_rd[b*8 +: 8];
        end
    end

    assign req = wb_cyc_i && wb_stb_i && !st_r.ack;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ack   = req;
        st_nxt.start = 1'b0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADR_CAP_LO:   st_nxt.dat = cap[31:0];
                ADR_CAP_HI:   st_nxt.dat = cap[63:32];
                ADR_CHK_ALO:  st_nxt.dat = st_r.alo;
                ADR_CHK_AHI:  st_nxt.dat = st_r.ahi;
                ADR_CHK_CTRL: st_nxt.dat = ctrl_rd;
                ADR_CHK_STAT: st_nxt.dat = stat_rd;
                default:      st_nxt.dat = 32'h0;
            endcase
        end
        // Writes to the capability words fall through untouched
        if (req && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] && wb_adr_i == ADR_CHK_ALO) begin
                    st_nxt.alo[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
                if (wb_sel_i[b] && wb_adr_i == ADR_CHK_AHI) begin
                    st_nxt.ahi[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
            if (wb_adr_i == ADR_CHK_CTRL) begin
                st_nxt.kind    = ctrl_wr[CTL_KIND_LSB +: 2];
                st_nxt.sel     = ctrl_wr[CTL_SEL_LSB +: 3];
                st_nxt.wr_only = ctrl_wr[CTL_WO_BIT];
                st_nxt.start   = 1'b1;
                st_nxt.pend    = 1'b1;
            end
        end
        // Verdict capture; reset, applied last, wins over a completing check
        if (chk.done) begin
            st_nxt.pend            = 1'b0;
            st_nxt.flags[ST_DONE]  = 1'b1;
            st_nxt.flags[ST_BLOCK] = chk.blocked;
            st_nxt.flags[ST_FAULT] = chk.fault;
            st_nxt.flags[ST_NULL]  = chk.null_cpl;
            st_nxt.flags[ST_BADW]  = chk.bad_width;
            if (chk.fault && st_r.cnt != CNT_MAX) begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
        if (reset) begin
            st_nxt = '0;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Clock enable freezes everything except reset, bus handshake included
    always_ff @(posedge clock) begin
        if (ce || reset) begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
endmodule : rcf_top
`default_nettype wire

// [rcf_top_chk.sv]
// Checker for rcf_top: bus timing and the capability read-out.
// Assumes it sees only the ports of rcf_top, through the bind below.
`timescale 1ns/1ps
`default_nettype none
module rcf_top_chk
    import rcf_pkg::*;
(
    // Clock, reset and enable
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        ce,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    // ****************************************************************
    // Expected words and read decode
    // ****************************************************************
    localparam logic [31:0] LO_EXP = {FOFS_VAL[7:0], 1'h0, ZLEN_VAL,
        MAXW_VAL, 3'h0, AWMSK_VAL, 8'h00};
    localparam logic [31:0] HI_EXP = {30'h0, FOFS_VAL[9:8]};
    logic rd;
    logic rd_lo;
    // Master holds the address while ack is high
    assign rd    = wb_ack_o && !wb_we_i;
    assign rd_lo = rd && (wb_adr_i == ADR_CAP_LO);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        ce |=> wb_ack_o) else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i && ce)) else $error("ack without request");
    ce_freeze_a: assert property (!ce |=> $stable(wb_ack_o) &&
        $stable(wb_dat_o)) else $error("outputs moved with ce low");
    cap_lo_a: assert property (
        rd_lo |-> wb_dat_o == LO_EXP) else $error("low word wrong");
    dep_zero_a: assert property (
        rd_lo |-> !wb_dat_o[23]) else $error("deprecated bit set");
    width_mask_a: assert property (
        rd_lo |-> !wb_dat_o[8] && !wb_dat_o[12] && wb_dat_o[12:8] ==
        (SLX_VAL ? AWMSK_CFG : 5'h00)) else $error("width mask wrong");
    host_width_a: assert property (
        rd_lo |-> wb_dat_o[21:16] >= HAW_M1) else $error("width too small");
    cap_hi_a: assert property (
        rd && wb_adr_i == ADR_CAP_HI |-> wb_dat_o == HI_EXP)
        else $error("high word wrong");
    unmapped_a: assert property (rd && wb_adr_i > ADR_CHK_STAT |->
        wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // Main scenarios reached
    cover property (rd_lo);
    cover property (wb_ack_o && wb_we_i);
    cover property (rd && wb_adr_i > ADR_CHK_STAT);
    cover property (!ce && wb_stb_i);
endmodule : rcf_top_chk
bind rcf_top rcf_top_chk rcf_top_chk_i (.clock(clock), .reset(reset),
    .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// [rcf_top_tb.sv]
// Self-checking bench for rcf_top: a table of register accesses, then
// address limit checks, clock enable and a reset in mid-run.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module rcf_top_tb
    import rcf_pkg::*;
;
    // ****************************************************************
    // Signals and table
    // ****************************************************************
    typedef struct packed {
        logic        we;
        logic [7:0]  a;
        logic [3:0]  s;
        logic [31:0] d;
        logic [31:0] e;
    } rcf_row_t;
    localparam logic [31:0] LO_EXP = {FOFS_VAL[7:0], 1'h0, ZLEN_VAL,
        MAXW_VAL, 3'h0, AWMSK_VAL, 8'h00};
    localparam logic [31:0] HI_EXP = {30'h0, FOFS_VAL[9:8]};
    localparam logic [63:0] TOP    = 64'h1 << (int'(MAXW_VAL) + 1);
    logic        clock, reset, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    int          mismatches = 0;
    int          checked = 0;
    int          cnt = 0;
    rcf_row_t    rows [15] = '{
        '{1'h0, ADR_CAP_LO, 4'hF, 32'h0, LO_EXP},
        '{1'h0, ADR_CAP_HI, 4'hF, 32'h0, HI_EXP},
        '{1'h1, ADR_CAP_LO, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, ADR_CAP_LO, 4'hF, 32'h0, LO_EXP},
        '{1'h1, ADR_CAP_HI, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, ADR_CAP_HI, 4'hF, 32'h0, HI_EXP},
        '{1'h1, ADR_CHK_ALO, 4'hF, 32'h12345678, 32'h0},
        '{1'h1, ADR_CHK_ALO, 4'h1, 32'hFFFFFFFF, 32'h0},
        '{1'h0, ADR_CHK_ALO, 4'hF, 32'h0, 32'h123456FF},
        '{1'h1, ADR_CHK_AHI, 4'h6, 32'hCAFEF00D, 32'h0},
        '{1'h0, ADR_CHK_AHI, 4'hF, 32'h0, 32'h00FEF000},
        '{1'h1, 8'h1C, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 8'h18, 4'hF, 32'h0, 32'h0},
        '{1'h1, ADR_CHK_STAT, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, ADR_CHK_STAT, 4'hF, 32'h0, 32'h0}};
    rcf_top rcf_top_i (.clock(clock), .reset(reset), .ce(ce),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    // One classic cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // Ack and data taken at the rising edge, before the slave updates
        @(posedge clock);
        while (wb_ack_o !== 1'h1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        if (n >= 40) mismatches++;
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        // Idle cycle so no strobe is set twice in one step
        @(posedge clock);
    endtask : wb
    // Load address and control, wait three cycles, then read the verdict once
    task automatic chk(input logic [5:0] c, input logic [63:0] a,
                       input logic [4:0] e);
        wb(1'h1, ADR_CHK_ALO, 4'hF, a[31:0]);
        wb(1'h1, ADR_CHK_AHI, 4'hF, a[63:32]);
        wb(1'h1, ADR_CHK_CTRL, 4'hF, {26'h0, c});
        repeat (3) @(posedge clock);
        wb(1'h0, ADR_CHK_STAT, 4'hF, 32'h0);
        cnt = cnt + int'(e[ST_FAULT]);
        `CHK(q[4:0], e)
        `CHK(q[15:8], cnt[7:0])
    endtask : chk
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // ****************************************************************
    // Clock, watchdog and sequence
    // ****************************************************************
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_sim();
    end
    initial begin
        reset <= 1'h1;
        ce <= 1'h1;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        wb_adr_i <= 8'h00;
        wb_sel_i <= 4'h0;
        wb_dat_i <= 32'h0;
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].a, rows[i].s, rows[i].d);
            if (!rows[i].we) `CHK(q, rows[i].e)
        end
        // Limit edges for sel 2, the only supported table, then the refused selects
        chk(6'h08, TOP - 64'h1, 5'h01);
        chk(6'h08, TOP, 5'h07);
        chk(6'h09, TOP, 5'h09);
        chk(6'h09, TOP - 64'h1, 5'h01);
        chk(6'h0B, TOP, 5'h07);
        chk(6'h2A, 64'h0, 5'h01);
        chk(6'h2A, TOP, 5'h07);
        chk(6'h05, 64'h0, 5'h19);
        for (int s = 0; s < 8; s++) begin
            if (s != 2) chk({1'h0, 3'(s), KIND_DMA}, 64'h0, 5'h17);
        end
        // Control word reads back the last select and kind
        wb(1'h0, ADR_CHK_CTRL, 4'hF, 32'h0);
        `CHK(q, 32'h0000001C)
        // Request waits while the clock enable is low
        ce <= 1'h0;
        fork
            wb(1'h0, ADR_CAP_LO, 4'hF, 32'h0);
            begin
                repeat (3) @(posedge clock);
                ce <= 1'h1;
            end
        join
        `CHK(q, LO_EXP)
        // Reset in mid-run clears state but not the capability
        wb(1'h1, ADR_CHK_ALO, 4'hF, 32'hA5A5A5A5);
        reset <= 1'h1;
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        wb(1'h0, ADR_CHK_ALO, 4'hF, 32'h0);
        `CHK(q, 32'h0)
        wb(1'h0, ADR_CHK_STAT, 4'hF, 32'h0);
        `CHK(q, 32'h0)
        wb(1'h0, ADR_CAP_LO, 4'hF, 32'h0);
        `CHK(q, LO_EXP)
        end_sim();
    end
endmodule : rcf_top_tb
`default_nettype wire
